// [aie_pkg.sv]
// Constants and types for the add instruction execution block
package aie_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned OPC_W = 16;
   localparam int unsigned FADDR_W = 12;
   localparam int unsigned BANK_W = 4;
   // Opcode patterns
   localparam logic [7:0] OPC_ADD_IMM = 8'h0f;
   localparam logic [5:0] OPC_ADD_FILE = 6'h09;
   localparam int unsigned POS_DEST = 9;
   localparam int unsigned POS_ACCESS = 8;
   // Access bank split and indexed window limit
   localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5f;
   localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
   localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;
   // Reset values
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   // Flag positions in the status vector
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_HALF_CARRY = 1;
   localparam int unsigned FLAG_Z = 2;
   localparam int unsigned FLAG_OVERFLOW = 3;
   localparam int unsigned FLAG_N = 4;
   // APB register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_OPCODE = 8'h04;
   localparam logic [7:0] REG_ACC = 8'h08;
   localparam logic [7:0] REG_BANK = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_INDEX_BASE = 8'h14;
   localparam logic [7:0] REG_FILE_PORT = 8'h18;
   // Q phase state, one-hot
   typedef enum logic [4:0] {
      AIE_IDLE = 5'b00001,
      AIE_Q1   = 5'b00010,
      AIE_Q2   = 5'b00100,
      AIE_Q3   = 5'b01000,
      AIE_Q4   = 5'b10000
   } aie_phase_e;
endpackage

// [aie_alu_if.sv]
// Operand and result bundle between the sequencer and the adder
`timescale 1ns/1ns
interface aie_alu_if;
   import aie_pkg::*;
   logic [DATA_W-1:0] op_a;
   logic [DATA_W-1:0] op_b;
   logic [DATA_W-1:0] sum;
   logic [4:0]        flags;
   modport core (output op_a, output op_b, input sum, input flags);
   modport alu (input op_a, input op_b, output sum, output flags);
endinterface

// [aie_adder.sv]
// Eight-bit adder with status flag generation
`timescale 1ns/1ns
module aie_adder
   import aie_pkg::*;
(
   aie_alu_if.alu bus
);
   logic [DATA_W:0] full;
   logic [4:0]      lo;

   always_comb begin
      full = {1'b0, bus.op_a} + {1'b0, bus.op_b};
      lo = {1'b0, bus.op_a[3:0]} + {1'b0, bus.op_b[3:0]};
      bus.sum = full[DATA_W-1:0];
      bus.flags[FLAG_C] = full[DATA_W];
      bus.flags[FLAG_HALF_CARRY] = lo[4];
      bus.flags[FLAG_Z] = (full[DATA_W-1:0] == 8'h00);
      // Same-sign operands giving an opposite-sign sum
      bus.flags[FLAG_OVERFLOW] = (bus.op_a[7] == bus.op_b[7])
                                 && (full[7] != bus.op_a[7]);
      bus.flags[FLAG_N] = full[7];
   end
endmodule

// [aie_core.sv]
// Sequencer, register file port and APB slave for the add instructions
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ns
module aie_core
   import aie_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   output logic [FADDR_W-1:0]      file_addr,
   output logic                    file_rd,
   output logic                    file_wr,
   output logic [DATA_W-1:0]       file_wdata,
   input  wire logic [DATA_W-1:0]  file_rdata,
   output logic                    busy
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   aie_phase_e             phase, next_phase;
   logic [OPC_W-1:0]       opcode, next_opcode;
   logic [DATA_W-1:0]      acc, next_acc;
   logic [BANK_W-1:0]      bank, next_bank;
   logic [4:0]             flags, next_flags;
   logic                   ext_en, next_ext_en;
   logic [FADDR_W-1:0]     idx_base, next_idx_base;
   logic [DATA_W-1:0]      operand, next_operand;
   logic [DATA_W-1:0]      result, next_result;
   logic [FADDR_W-1:0]     ea, next_ea;
   logic                   is_imm, next_is_imm;
   logic [FADDR_W-1:0]     next_file_addr;
   logic                   next_file_rd, next_file_wr;
   logic [DATA_W-1:0]      next_file_wdata;
   logic [31:0]            next_prdata;

   aie_alu_if alu_bus ();

   aie_adder u_adder (
      .bus (alu_bus.alu)
   );

   // ----------------------------------------------------------------
   // Effective address
   // ----------------------------------------------------------------
   function automatic logic [FADDR_W-1:0] resolve(input logic [OPC_W-1:0] op,
                                                 input logic [BANK_W-1:0] bsel,
                                                 input logic xen,
                                                 input logic [FADDR_W-1:0] base);
      logic [7:0] f;
      f = op[7:0];
      if (!op[POS_ACCESS] && xen && (f <= INDEXED_LIMIT)) begin
         resolve = base + {4'h0, f};
      end else if (!op[POS_ACCESS]) begin
         // Access bank: low part of bank 0 or top of the last bank
         resolve = (f <= ACCESS_LOW_LIMIT) ? {4'h0, f} : {ACCESS_HIGH_BANK, f};
      end else begin
         resolve = {bsel, f};
      end
   endfunction

   wire logic apb_wr = psel && penable && pwrite;
   wire logic start = apb_wr && (paddr == REG_OPCODE) && (phase == AIE_IDLE);

   always_comb begin
      alu_bus.op_a = acc;
      alu_bus.op_b = operand;
   end

   // ----------------------------------------------------------------
   // Next values
   // ----------------------------------------------------------------
   always_comb begin
      next_phase = phase;
      next_opcode = opcode;
      next_acc = acc;
      next_bank = bank;
      next_flags = flags;
      next_ext_en = ext_en;
      next_idx_base = idx_base;
      next_operand = operand;
      next_result = result;
      next_ea = ea;
      next_is_imm = is_imm;
      next_file_addr = file_addr;
      next_file_rd = 1'b0;
      next_file_wr = 1'b0;
      next_file_wdata = file_wdata;
      unique case (phase)
         AIE_IDLE: begin
            if (start) begin
               next_opcode = pwdata[OPC_W-1:0];
               next_phase = AIE_Q1;
            end
         end
         AIE_Q1: begin
            // Decode; anything else returns to idle with only ea and is_imm updated
            next_is_imm = (opcode[15:8] == OPC_ADD_IMM);
            next_ea = resolve(opcode, bank, ext_en, idx_base);
            if (opcode[15:8] == OPC_ADD_IMM) begin
               next_phase = AIE_Q2;
            end else if (opcode[15:10] == OPC_ADD_FILE) begin
               next_phase = AIE_Q2;
               next_file_addr = resolve(opcode, bank, ext_en, idx_base);
               next_file_rd = 1'b1;
            end else begin
               next_phase = AIE_IDLE;
            end
         end
         AIE_Q2: begin
            // Read literal or file data
            next_operand = is_imm ? opcode[7:0] : file_rdata;
            next_phase = AIE_Q3;
         end
         AIE_Q3: begin
            next_result = alu_bus.sum;
            next_flags = alu_bus.flags;
            next_phase = AIE_Q4;
         end
         AIE_Q4: begin
            if (is_imm || !opcode[POS_DEST]) begin
               next_acc = result;
            end else begin
               next_file_addr = ea;
               next_file_wdata = result;
               next_file_wr = 1'b1;
            end
            next_phase = AIE_IDLE;
         end
      endcase
      // Register writes other than the opcode; ignored while executing
      if (apb_wr && (phase == AIE_IDLE)) begin
         unique case (paddr)
            REG_CTRL: next_ext_en = pwdata[0];
            REG_ACC: next_acc = pwdata[7:0];
            REG_BANK: next_bank = pwdata[BANK_W-1:0];
            REG_STATUS: next_flags = pwdata[4:0];
            REG_INDEX_BASE: next_idx_base = pwdata[FADDR_W-1:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
         REG_CTRL: next_prdata = {30'h0, busy, ext_en};
         REG_OPCODE: next_prdata = {16'h0, opcode};
         REG_ACC: next_prdata = {24'h0, acc};
         REG_BANK: next_prdata = {28'h0, bank};
         REG_STATUS: next_prdata = {27'h0, flags};
         REG_INDEX_BASE: next_prdata = {20'h0, idx_base};
         REG_FILE_PORT: next_prdata = {20'h0, ea};
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   always_comb begin
      pready = 1'b1;
      pslverr = psel && penable && (paddr > REG_FILE_PORT || paddr[1:0] != 2'b00);
      busy = (phase != AIE_IDLE);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= AIE_IDLE;
         opcode <= 16'h0000;
         acc <= ACC_RESET;
         bank <= BANK_RESET;
         flags <= FLAGS_RESET;
         ext_en <= 1'b0;
         idx_base <= 12'h000;
         operand <= 8'h00;
         result <= 8'h00;
         ea <= 12'h000;
         is_imm <= 1'b0;
         file_addr <= 12'h000;
         file_rd <= 1'b0;
         file_wr <= 1'b0;
         file_wdata <= 8'h00;
         prdata <= 32'h0000_0000;
      end else begin
         phase <= next_phase;
         opcode <= next_opcode;
         acc <= next_acc;
         bank <= next_bank;
         flags <= next_flags;
         ext_en <= next_ext_en;
         idx_base <= next_idx_base;
         operand <= next_operand;
         result <= next_result;
         ea <= next_ea;
         is_imm <= next_is_imm;
         file_addr <= next_file_addr;
         file_rd <= next_file_rd;
         file_wr <= next_file_wr;
         file_wdata <= next_file_wdata;
         prdata <= (psel && !penable) ? next_prdata : prdata;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   phase_walk_a: assert property (
      phase == AIE_Q2 |=> phase == AIE_Q3 ##1 phase == AIE_Q4 ##1 phase == AIE_IDLE)
      else $error("phase walk broken");
   imm_sum_a: assert property (phase == AIE_Q4 && is_imm |=> acc == result)
      else $error("immediate sum not in accumulator");
   dest_w_a: assert property (
      phase == AIE_Q4 && !is_imm && !opcode[POS_DEST] |=> !file_wr && acc == result)
      else $error("dest zero wrote file");
   dest_f_a: assert property (
      phase == AIE_Q4 && !is_imm && opcode[POS_DEST]
      |=> file_wr && file_wdata == result && $stable(acc))
      else $error("dest one missed file write");
   bank_sel_a: assert property (
      phase == AIE_Q1 && opcode[15:10] == OPC_ADD_FILE && opcode[POS_ACCESS]
      |=> file_rd && file_addr == {$past(bank), $past(opcode[7:0])})
      else $error("bank select address wrong");
   indexed_a: assert property (
      phase == AIE_Q1 && opcode[15:10] == OPC_ADD_FILE && !opcode[POS_ACCESS] && ext_en
      && opcode[7:0] <= INDEXED_LIMIT
      |=> file_addr == $past(idx_base) + {4'h0, $past(opcode[7:0])})
      else $error("indexed address wrong");
   file_read_a: assert property (file_rd |=> operand == $past(file_rdata))
      else $error("file operand not captured");
   flags_z_a: assert property (phase == AIE_Q3 |=> flags[FLAG_Z] == (result == 8'h00))
      else $error("zero flag wrong");
   imm_cov: cover property (phase == AIE_Q4 && is_imm);
   wdest_cov: cover property (phase == AIE_Q4 && !is_imm && !opcode[POS_DEST]);
   fdest_cov: cover property (file_wr);
   idx_cov: cover property (phase == AIE_Q1 && ext_en && !opcode[POS_ACCESS]);
endmodule

// [aie_core_tb.sv]
// Self-checking bench for the add instruction execution core
`timescale 1ns/1ns
module aie_core_tb;
   import aie_pkg::*;
   logic                pclk;
   logic                presetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [7:0]          paddr;
   logic [31:0]         pwdata;
   logic                pready;
   logic [31:0]         prdata;
   logic                pslverr;
   logic [FADDR_W-1:0]  file_addr;
   logic                file_rd;
   logic                file_wr;
   logic [DATA_W-1:0]   file_wdata;
   logic [DATA_W-1:0]   file_rdata;
   logic                busy;
   logic [7:0]          mem [0:4095];
   logic                err;
   logic [31:0]         rd;
   int                  fail_count = 0;
   int                  checked = 0;
   int                  cycles = 0;

   aie_core aie_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
      .file_wdata(file_wdata), .file_rdata(file_rdata), .busy(busy));

   // ------------------------------------------------------------
   // Data memory and timeout
   // ------------------------------------------------------------
   assign file_rdata = mem[file_addr];
   always @(posedge pclk) begin
      if (file_wr === 1'b1) begin
         mem[file_addr] <= file_wdata;
      end
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         end_of_test();
      end
   end

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits for pready, takes data at that edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [4:0] exp_flags(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      logic [4:0] f;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      f = 5'h00;
      f[FLAG_C] = s[8];
      f[FLAG_HALF_CARRY] = h[4];
      f[FLAG_Z] = (s[7:0] == 8'h00);
      f[FLAG_OVERFLOW] = (a[7] == b[7]) && (s[7] != a[7]);
      f[FLAG_N] = s[7];
      return f;
   endfunction

   // Runs one add; watches the memory strobes phase by phase
   task automatic run_op(input logic [15:0] op, input logic [7:0] acc0, input logic [7:0] mv,
                         input logic [11:0] ea, input logic fil);
      logic [7:0]  b;
      logic [7:0]  s;
      logic [11:0] rd_addr;
      int          rd_at;
      int          wr_at;
      int          busy_n;
      b = fil ? mv : op[7:0];
      s = acc0 + b;
      rd_at = 0;
      wr_at = 0;
      busy_n = 0;
      rd_addr = 12'h000;
      mem[ea] = mv;
      apb(1'b1, REG_ACC, {24'h000000, acc0});
      apb(1'b1, REG_OPCODE, {16'h0000, op});
      for (int n = 1; n <= 6; n++) begin
         @(posedge pclk);
         #1;
         if (file_rd === 1'b1) begin
            rd_at = n;
            rd_addr = file_addr;
         end
         if (file_wr === 1'b1) begin
            wr_at = n;
         end
         if (busy === 1'b1) begin
            busy_n = n;
         end
      end
      chk(rd_at, fil ? 1 : 0);
      chk(busy_n, 3);
      chk(wr_at, (fil && op[POS_DEST]) ? 4 : 0);
      if (fil) chk(rd_addr, ea);
      apb(1'b0, REG_ACC, 32'h0);
      chk(rd, (fil && op[POS_DEST]) ? acc0 : s);
      chk(mem[ea], (fil && op[POS_DEST]) ? s : mv);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd, exp_flags(acc0, b));
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd[1], 1'b0);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      apb(1'b0, REG_ACC, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_imm();
      run_op(16'h0f15, 8'h10, 8'h00, 12'h001, 1'b0);
      run_op(16'h0f01, 8'h7f, 8'h00, 12'h001, 1'b0);
      run_op(16'h0fff, 8'h01, 8'h00, 12'h001, 1'b0);
      $display("test immediate done");
   endtask

   task automatic t_file();
      apb(1'b1, REG_BANK, 32'h3);
      run_op(16'h2542, 8'h11, 8'h33, 12'h342, 1'b1);
      run_op(16'h2680, 8'h90, 8'h90, 12'hf80, 1'b1);
      run_op(16'h2620, 8'h01, 8'h0f, 12'h020, 1'b1);
      apb(1'b0, REG_FILE_PORT, 32'h0);
      chk(rd, 32'h020);
      $display("test file add done");
   endtask

   task automatic t_indexed();
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b1, REG_INDEX_BASE, 32'h200);
      run_op(16'h265f, 8'h08, 8'h08, 12'h25f, 1'b1);
      run_op(16'h2660, 8'h80, 8'h80, 12'hf60, 1'b1);
      run_op(16'h2710, 8'h22, 8'h44, 12'h310, 1'b1);
      $display("test indexed done");
   endtask

   task automatic t_refuse();
      apb(1'b0, 8'h1c, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, REG_ACC, 32'h5a);
      apb(1'b1, REG_OPCODE, 32'h0b05);
      repeat (6) @(posedge pclk);
      apb(1'b0, REG_ACC, 32'h0);
      chk(rd, 32'h5a);
      // Neighbouring opcode pattern with carry-in must not be taken as a file add
      apb(1'b1, REG_OPCODE, 32'h2342);
      repeat (6) @(posedge pclk);
      apb(1'b0, REG_ACC, 32'h0);
      chk(rd, 32'h5a);
      $display("test refusal done");
   endtask

   task automatic t_busy();
      apb(1'b1, REG_ACC, 32'h01);
      apb(1'b1, REG_OPCODE, 32'h0f02);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd[1], 1'b1);
      apb(1'b1, REG_OPCODE, 32'h0f02);
      // Lands while the second add runs, so it must be ignored
      apb(1'b1, REG_ACC, 32'h77);
      repeat (4) @(posedge pclk);
      apb(1'b0, REG_ACC, 32'h0);
      chk(rd, 32'h05);
      $display("test busy done");
   endtask

   // Reset in mid-instruction must abandon the pending write-back
   task automatic t_mid_reset();
      mem[12'h230] = 8'h11;
      apb(1'b1, REG_ACC, 32'h40);
      apb(1'b1, REG_OPCODE, 32'h2630);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) begin
         @(posedge pclk);
         #1;
         chk({busy, file_wr}, 2'b00);
      end
      apb(1'b0, REG_ACC, 32'h0);
      chk(rd, {24'h0, ACC_RESET});
      chk(mem[12'h230], 8'h11);
      $display("test mid-run reset done");
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_imm();
      t_file();
      t_indexed();
      t_busy();
      t_refuse();
      t_mid_reset();
      end_of_test();
   end
endmodule
